// ### hw/su_device.sv
// Serial unit: async receiver with marker addressing, transmitter, AHB-Lite registers
// What this block does
// - Detect start bit, shift frame, check parity/stop
// - Full at completion: set overrun, drop data
// - Any error flag with enable raises error request
// - Parity mismatch flags error, data still transferred
// - Stop bit zero flags framing, data still transferred
// - Clean frame: transfer, set full, request if enabled
// - Errors keep full; overrun loses data, others transfer
// - No new reception while error flags are set
// - Reader empties data before next stop bit
// - Transfer controller read clears full automatically
// - Marker one means ID, zero means data
// - Wait mode suppresses everything until ID frame
// - ID frame sets marker status, ends wait, transfers
// - Marker format ignores the parity enable
// - Software chooses sent marker; unit sends it
// - Station skips frames until its own ID
// - Transmit enable first sends one all-ones frame
// - Transfer controller write clears transmit empty
// - Break: port drives low, then transmit off
// - Receive pin becomes input when receiving
// - 16x basic clock, sample at eighth pulse
// - Start, 7/8 data, optional extra, 1/2 stop
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module su_device
	import su_pkg::*;
#(
	parameter int BASIC_DIV = SU_BASIC_DIV
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	su_line_if.dev_end       line,
	input  wire logic        port_dir,
	input  wire logic        port_output_value,
	input  wire logic        tc_rx_read,
	output logic [7:0]       tc_rx_data,
	input  wire logic        tc_tx_write,
	input  wire logic [7:0]  tc_tx_data,
	output logic             rx_full_irq,
	output logic             rx_error_irq,
	output logic             tx_empty_irq
);
	logic [SU_C_W-1:0] serial_control_reg;
	logic [6:0]        serial_status_reg;
	logic [7:0]        rx_data_reg;
	logic [7:0]        tx_data_reg;
	su_fmt_type        fmt;
	logic [15:0]       div;
	logic              tick;
	logic              wr_pend;
	logic [3:0]        wr_addr;
	logic              wr_ctrl;
	logic              wr_stat;
	su_state_type      rx_state;
	logic [3:0]        tcnt;
	logic [2:0]        bcnt;
	logic [7:0]        rx_shift_reg;
	logic              rx_ext;
	logic              rx_in;
	logic              rx_prev;
	logic              any_err;
	logic              done;
	logic              skip;
	logic              ovr_ev;
	logic              fer_ev;
	logic              per_ev;
	logic              xfer;
	logic              tx_en_q;
	logic              pre_sent;
	logic              pre_done;
	logic              tx_busy;
	logic              tx_go;
	logic              pre_go;
	logic              txd;

	assign fmt     = su_fmt_type'({<<{serial_control_reg[SU_C_FMT +: 5]}});
	assign tick    = (div == 16'(BASIC_DIV - 1));
	assign any_err = serial_status_reg[SU_S_OVR] | serial_status_reg[SU_S_FER]
		| serial_status_reg[SU_S_PER];
	assign rx_in   = serial_control_reg[SU_C_RXEN] ? line.stn_to_dev : 1'b1;

	// Zero wait states keep the master's handshake trivial
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_ctrl   = wr_pend && (wr_addr == SU_OFS_CTRL);
	assign wr_stat   = wr_pend && (wr_addr == SU_OFS_STAT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= 16'h0000;
		end else begin
			div <= tick ? 16'h0000 : div + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 4'h0;
			hrdata  <= 32'h0000_0000;
		end else begin
			wr_pend <= hsel && hready && htrans[1] && hwrite;
			wr_addr <= haddr[3:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				case (haddr[3:0])
					SU_OFS_CTRL: hrdata <= {22'h000000, serial_control_reg};
					SU_OFS_STAT: hrdata <= {25'h0000000, serial_status_reg};
					SU_OFS_RXD:  hrdata <= {24'h000000, rx_data_reg};
					SU_OFS_TXD:  hrdata <= {24'h000000, tx_data_reg};
					default:     hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Receive sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_prev      <= 1'b1;
			rx_state     <= SU_ST_IDLE;
			tcnt         <= 4'h0;
			bcnt         <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_ext       <= 1'b0;
		end else begin
			rx_prev <= rx_in;
			case (rx_state)
				SU_ST_IDLE: if (!any_err && rx_prev && !rx_in) begin
					rx_state     <= SU_ST_START;
					tcnt         <= 4'h0;
					rx_shift_reg <= 8'h00;
				end
				SU_ST_START: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_MID_CNT) begin
						tcnt     <= 4'h0;
						bcnt     <= 3'h0;
						rx_state <= rx_in ? SU_ST_IDLE : SU_ST_DATA;
					end
				end
				SU_ST_DATA: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_BIT_CNT) begin
						rx_shift_reg[bcnt] <= rx_in;
						bcnt               <= bcnt + 3'h1;
						if (bcnt == su_last_bit(fmt)) begin
							rx_state <= su_has_extra(fmt) ? SU_ST_EXTRA : SU_ST_STOP;
						end
					end
				end
				SU_ST_EXTRA: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_BIT_CNT) begin
						rx_ext   <= rx_in;
						rx_state <= SU_ST_STOP;
					end
				end
				SU_ST_STOP: if (done) begin
					rx_state <= SU_ST_IDLE;
				end else if (tick) begin
					tcnt <= tcnt + 4'h1;
				end
				default: rx_state <= SU_ST_IDLE;
			endcase
		end
	end

	// Frame outcome, decided at the first stop bit
	always_comb begin
		done   = (rx_state == SU_ST_STOP) && tick && (tcnt == SU_BIT_CNT);
		skip   = fmt.mp_format && serial_control_reg[SU_C_MP_WAIT_ENABLE] && !rx_ext;
		ovr_ev = done && !skip && serial_status_reg[SU_S_FULL];
		fer_ev = done && !skip && !rx_in;
		per_ev = done && !skip && fmt.parity_en && !fmt.mp_format
			&& (rx_ext != su_parity(rx_shift_reg, fmt));
		xfer   = done && !skip && !serial_status_reg[SU_S_FULL];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_data_reg <= 8'h00;
		end else if (xfer) begin
			rx_data_reg <= rx_shift_reg;
		end
	end

	assign tc_rx_data = rx_data_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_control_reg <= SU_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				serial_control_reg <= hwdata[SU_C_W-1:0];
			end
			if (done && fmt.mp_format && serial_control_reg[SU_C_MP_WAIT_ENABLE] && rx_ext) begin
				serial_control_reg[SU_C_MP_WAIT_ENABLE] <= 1'b0;
			end
		end
	end

	// Software clears a flag by writing zero to it; a hardware set in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_status_reg <= SU_STAT_RST;
		end else begin
			if (wr_stat) begin
				serial_status_reg[SU_S_FULL] <= serial_status_reg[SU_S_FULL] & hwdata[SU_S_FULL];
				serial_status_reg[SU_S_OVR]  <= serial_status_reg[SU_S_OVR] & hwdata[SU_S_OVR];
				serial_status_reg[SU_S_FER]  <= serial_status_reg[SU_S_FER] & hwdata[SU_S_FER];
				serial_status_reg[SU_S_PER]  <= serial_status_reg[SU_S_PER] & hwdata[SU_S_PER];
				serial_status_reg[SU_S_TXE]  <= serial_status_reg[SU_S_TXE] & hwdata[SU_S_TXE];
				serial_status_reg[SU_S_MP_BIT_TRANSMIT] <= hwdata[SU_S_MP_BIT_TRANSMIT];
			end
			if (tc_rx_read) begin
				serial_status_reg[SU_S_FULL] <= 1'b0;
			end
			if (tc_tx_write) begin
				serial_status_reg[SU_S_TXE] <= 1'b0;
			end
			if (xfer && !fer_ev && !per_ev) begin
				serial_status_reg[SU_S_FULL] <= 1'b1;
			end
			if (ovr_ev) begin
				serial_status_reg[SU_S_OVR] <= 1'b1;
			end
			if (fer_ev) begin
				serial_status_reg[SU_S_FER] <= 1'b1;
			end
			if (per_ev) begin
				serial_status_reg[SU_S_PER] <= 1'b1;
			end
			if (done && fmt.mp_format && !skip) begin
				serial_status_reg[SU_S_MPBR] <= rx_ext;
			end
			if (tx_go || !serial_control_reg[SU_C_TXEN]) begin
				serial_status_reg[SU_S_TXE] <= 1'b1;
			end
		end
	end

	assign rx_full_irq  = serial_control_reg[SU_C_RIE] && serial_status_reg[SU_S_FULL];
	assign rx_error_irq = serial_control_reg[SU_C_RIE] && any_err;
	assign tx_empty_irq = serial_control_reg[SU_C_TIE] && serial_status_reg[SU_S_TXE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_data_reg <= 8'h00;
		end else if (tc_tx_write) begin
			tx_data_reg <= tc_tx_data;
		end else if (wr_pend && (wr_addr == SU_OFS_TXD)) begin
			tx_data_reg <= hwdata[7:0];
		end
	end

	// Idle frame after enabling lets receivers on the line resynchronise
	assign pre_go = serial_control_reg[SU_C_TXEN] && !pre_sent && !tx_busy;
	assign tx_go  = serial_control_reg[SU_C_TXEN] && pre_done && !tx_busy
		&& !serial_status_reg[SU_S_TXE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_en_q  <= 1'b0;
			pre_sent <= 1'b0;
			pre_done <= 1'b0;
		end else begin
			tx_en_q <= serial_control_reg[SU_C_TXEN];
			if (!serial_control_reg[SU_C_TXEN]) begin
				pre_sent <= 1'b0;
				pre_done <= 1'b0;
			end else if (pre_go) begin
				pre_sent <= 1'b1;
			end else if (pre_sent && tx_en_q && !tx_busy) begin
				pre_done <= 1'b1;
			end
		end
	end

	su_frame_tx u_tx (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.tick      (tick),
		.fmt       (fmt),
		.start     (pre_go || tx_go),
		.mark_only (pre_go),
		.data      (tx_data_reg),
		.marker    (serial_status_reg[SU_S_MP_BIT_TRANSMIT]),
		.txd       (txd),
		.busy      (tx_busy)
	);

	// With transmit off the port logic owns the pin, which is how a break is sent
	assign line.dev_to_stn = serial_control_reg[SU_C_TXEN] ? txd
		: (port_dir ? port_output_value : 1'b1);
endmodule // su_device

// ### hw/su_frame_tx.sv
// Frame transmitter running on the 16x basic clock enable
`timescale 1ns/1ps
module su_frame_tx
	import su_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       tick,
	input  wire su_fmt_type fmt,
	input  wire logic       start,
	input  wire logic       mark_only,
	input  wire logic [7:0] data,
	input  wire logic       marker,
	output logic            txd,
	output logic            busy
);
	su_state_type state;
	logic [3:0]   tcnt;
	logic [2:0]   bcnt;
	logic [7:0]   shift;
	logic         ext;
	logic         mark;
	logic         second;
	logic         line_bit;
	logic         pend;

	assign busy = (state != SU_ST_IDLE) || pend;

	always_comb begin
		case (state)
			SU_ST_START: line_bit = 1'b0;
			SU_ST_DATA:  line_bit = shift[bcnt];
			SU_ST_EXTRA: line_bit = ext;
			default:     line_bit = 1'b1;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txd <= 1'b1;
		end else begin
			txd <= mark | line_bit;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state  <= SU_ST_IDLE;
			tcnt   <= 4'h0;
			bcnt   <= 3'h0;
			shift  <= 8'h00;
			ext    <= 1'b1;
			mark   <= 1'b0;
			second <= 1'b0;
			pend   <= 1'b0;
		end else begin
			case (state)
				SU_ST_IDLE: begin
					if (start) begin
						pend   <= 1'b1;
						shift  <= data;
						mark   <= mark_only;
						second <= 1'b0;
						ext    <= fmt.mp_format ? marker : su_parity(data, fmt);
					end
					// Wait for a tick so the start bit is as long as every other bit
					if (pend && tick) begin
						pend  <= 1'b0;
						state <= SU_ST_START;
						tcnt  <= 4'h0;
						bcnt  <= 3'h0;
					end
				end
				default: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_BIT_CNT) begin
						case (state)
							SU_ST_START: state <= SU_ST_DATA;
							SU_ST_DATA: begin
								bcnt <= bcnt + 3'h1;
								if (bcnt == su_last_bit(fmt)) begin
									state <= su_has_extra(fmt) ? SU_ST_EXTRA : SU_ST_STOP;
								end
							end
							SU_ST_EXTRA: state <= SU_ST_STOP;
							default: begin
								second <= 1'b1;
								if (!fmt.two_stop || second) begin
									state <= SU_ST_IDLE;
									mark  <= 1'b0;
								end
							end
						endcase
					end
				end
			endcase
		end
	end
endmodule // su_frame_tx

// ### hw/su_station.sv
// Partner station: sends frames and receives with ID filtering in marker format
`timescale 1ns/1ps
module su_station
	import su_pkg::*;
#(
	parameter int BASIC_DIV = SU_BASIC_DIV
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	su_line_if.stn_end      line,
	input  wire su_fmt_type fmt,
	input  wire logic [7:0] own_id,
	input  wire logic       send_req,
	input  wire logic [7:0] send_data,
	input  wire logic       send_marker,
	output logic            send_ready,
	input  wire logic       break_req,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_marker,
	output logic            rx_error
);
	logic [15:0]  div;
	logic         tick;
	logic         txd;
	logic         busy;
	su_state_type rx_state;
	logic [3:0]   tcnt;
	logic [2:0]   bcnt;
	logic [7:0]   shift;
	logic         ext;
	logic         rx_prev;
	logic         skipping;
	logic         done;

	assign tick       = (div == 16'(BASIC_DIV - 1));
	assign send_ready = !busy;
	assign line.stn_to_dev = txd & !break_req;
	assign done = (rx_state == SU_ST_STOP) && tick && (tcnt == SU_BIT_CNT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= 16'h0000;
		end else begin
			div <= tick ? 16'h0000 : div + 16'h0001;
		end
	end

	su_frame_tx u_tx (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.tick      (tick),
		.fmt       (fmt),
		.start     (send_req && !busy),
		.mark_only (1'b0),
		.data      (send_data),
		.marker    (send_marker),
		.txd       (txd),
		.busy      (busy)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_prev  <= 1'b1;
			rx_state <= SU_ST_IDLE;
			tcnt     <= 4'h0;
			bcnt     <= 3'h0;
			shift    <= 8'h00;
			ext      <= 1'b0;
		end else begin
			rx_prev <= line.dev_to_stn;
			case (rx_state)
				SU_ST_IDLE: if (rx_prev && !line.dev_to_stn) begin
					rx_state <= SU_ST_START;
					tcnt     <= 4'h0;
					shift    <= 8'h00;
				end
				SU_ST_START: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_MID_CNT) begin
						tcnt     <= 4'h0;
						bcnt     <= 3'h0;
						rx_state <= line.dev_to_stn ? SU_ST_IDLE : SU_ST_DATA;
					end
				end
				SU_ST_DATA: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_BIT_CNT) begin
						shift[bcnt] <= line.dev_to_stn;
						bcnt        <= bcnt + 3'h1;
						if (bcnt == su_last_bit(fmt)) begin
							rx_state <= su_has_extra(fmt) ? SU_ST_EXTRA : SU_ST_STOP;
						end
					end
				end
				SU_ST_EXTRA: if (tick) begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == SU_BIT_CNT) begin
						ext      <= line.dev_to_stn;
						rx_state <= SU_ST_STOP;
					end
				end
				SU_ST_STOP: if (done) begin
					rx_state <= SU_ST_IDLE;
				end else if (tick) begin
					tcnt <= tcnt + 4'h1;
				end
				default: rx_state <= SU_ST_IDLE;
			endcase
		end
	end

	// Starts skipping so that data aimed at other stations is never delivered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skipping  <= 1'b1;
			rx_valid  <= 1'b0;
			rx_data   <= 8'h00;
			rx_marker <= 1'b0;
			rx_error  <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (done && fmt.mp_format && ext) begin
				skipping <= (shift != own_id);
			end
			if (done && (!fmt.mp_format || (!ext && !skipping))) begin
				rx_valid  <= 1'b1;
				rx_data   <= shift;
				rx_marker <= ext;
				rx_error  <= !line.dev_to_stn
					|| (fmt.parity_en && !fmt.mp_format && (ext != su_parity(shift, fmt)));
			end
		end
	end
endmodule // su_station

// ### inc/su_line_if.sv
// Asynchronous serial line between the serial unit and a partner station
`timescale 1ns/1ps
interface su_line_if;
	logic dev_to_stn;
	logic stn_to_dev;
	modport dev_end (output dev_to_stn, input stn_to_dev);
	modport stn_end (output stn_to_dev, input dev_to_stn);
endinterface // su_line_if

// ### inc/su_pkg.sv
// Shared constants, types and decoders of the serial unit and its partner station
package su_pkg;
	localparam int SU_CLK_HZ     = 125_000_000;
	localparam int SU_BIT_RATE   = 115_200;
	localparam int SU_OVERSAMPLE = 16;
	localparam int SU_MID_TICK   = 8;
	localparam int SU_BASIC_DIV  = SU_CLK_HZ / (SU_OVERSAMPLE * SU_BIT_RATE);

	localparam logic [3:0] SU_MID_CNT = 4'(SU_MID_TICK - 1);
	localparam logic [3:0] SU_BIT_CNT = 4'(SU_OVERSAMPLE - 1);

	localparam logic [3:0] SU_OFS_CTRL = 4'h0;
	localparam logic [3:0] SU_OFS_STAT = 4'h4;
	localparam logic [3:0] SU_OFS_RXD  = 4'h8;
	localparam logic [3:0] SU_OFS_TXD  = 4'hC;

	localparam int SU_C_RXEN  = 0;
	localparam int SU_C_TXEN  = 1;
	localparam int SU_C_RIE   = 2;
	localparam int SU_C_MP_WAIT_ENABLE  = 3;
	localparam int SU_C_TIE   = 4;
	localparam int SU_C_FMT   = 5;
	localparam int SU_C_W     = 10;
	localparam logic [9:0] SU_CTRL_RST = 10'h000;

	localparam int SU_S_FULL = 0;
	localparam int SU_S_OVR  = 1;
	localparam int SU_S_FER  = 2;
	localparam int SU_S_PER  = 3;
	localparam int SU_S_MPBR = 4;
	localparam int SU_S_TXE  = 5;
	localparam int SU_S_MP_BIT_TRANSMIT = 6;
	localparam logic [6:0] SU_STAT_RST = 7'h20;

	typedef struct packed {
		logic seven_bit;
		logic parity_en;
		logic parity_odd;
		logic mp_format;
		logic two_stop;
	} su_fmt_type;

	typedef enum logic [4:0] {
		SU_ST_IDLE  = 5'b00001,
		SU_ST_START = 5'b00010,
		SU_ST_DATA  = 5'b00100,
		SU_ST_EXTRA = 5'b01000,
		SU_ST_STOP  = 5'b10000
	} su_state_type;

	// Parity setting counts for nothing in marker format
	function automatic logic su_has_extra(input su_fmt_type f);
		return f.mp_format | f.parity_en;
	endfunction

	function automatic logic [2:0] su_last_bit(input su_fmt_type f);
		return f.seven_bit ? 3'h6 : 3'h7;
	endfunction

	function automatic logic su_parity(input logic [7:0] d, input su_fmt_type f);
		return (^(f.seven_bit ? {1'b0, d[6:0]} : d)) ^ f.parity_odd;
	endfunction
endpackage

// ### testbench/su_device_bench.sv
// Bench joining the serial unit and a partner station over the shared line
`timescale 1ns/1ps
module su_device_bench
	import su_pkg::*;
;
	localparam int DIV = 2;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, port_dir, port_output_value;
	logic        tc_rx_read, tc_tx_write, send_req, send_marker;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  tc_tx_data, send_data, own_id;
	su_fmt_type  fmt;
	wire logic   hreadyout, hresp, rx_full_irq, rx_error_irq, tx_empty_irq;
	wire logic   send_ready, rx_valid, rx_marker, rx_error;
	wire logic [31:0] hrdata;
	wire logic [7:0]  tc_rx_data, rx_data;
	int          n_errors = 0;
	int          checks = 0;

	always #4 hclk = ~hclk;

	su_line_if su_line_if_inst ();
	su_device #(.BASIC_DIV(DIV)) su_device_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.line(su_line_if_inst.dev_end), .port_dir(port_dir),
		.port_output_value(port_output_value), .tc_rx_read(tc_rx_read),
		.tc_rx_data(tc_rx_data), .tc_tx_write(tc_tx_write), .tc_tx_data(tc_tx_data),
		.rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_empty_irq(tx_empty_irq));
	su_station #(.BASIC_DIV(DIV)) su_station_inst (.hclk(hclk), .hresetn(hresetn),
		.line(su_line_if_inst.stn_end), .fmt(fmt), .own_id(own_id), .send_req(send_req),
		.send_data(send_data), .send_marker(send_marker), .send_ready(send_ready),
		.break_req(1'b0), .rx_valid(rx_valid), .rx_data(rx_data), .rx_marker(rx_marker),
		.rx_error(rx_error));
	su_line_chk #(.BASIC_DIV(DIV)) su_line_chk_inst (.hclk(hclk), .hresetn(hresetn),
		.dev_to_stn(su_line_if_inst.dev_to_stn), .stn_to_dev(su_line_if_inst.stn_to_dev));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic stuck(input string what);
		n_errors++;
		$display("unexpected at %0t: %s never came", $time, what);
		wrap_up();
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50)
				stuck("hready");
			@(posedge hclk);
		end
	endtask

	// Address phase held until hready, then data phase held until hready
	task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {28'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(x, exp, what);
	endtask

	// Waits for the station to finish, so the unit has sampled the stop bit
	task automatic send(input logic [7:0] d, input logic m);
		int n;
		n = 0;
		@(posedge hclk);
		send_req <= 1'b1;
		send_data <= d;
		send_marker <= m;
		@(posedge hclk);
		send_req <= 1'b0;
		repeat (4) @(posedge hclk);
		while (send_ready !== 1'b1) begin
			n++;
			if (n > 1000)
				stuck("station idle");
			@(posedge hclk);
		end
		repeat (4) @(posedge hclk);
	endtask

	task automatic tc_read;
		@(posedge hclk);
		tc_rx_read <= 1'b1;
		@(posedge hclk);
		tc_rx_read <= 1'b0;
		@(posedge hclk);
	endtask

	task automatic t_regs;
		rd_chk(SU_OFS_CTRL, 32'h0, "ctrl reset");
		rd_chk(SU_OFS_STAT, 32'h20, "status reset");
		wr(SU_OFS_RXD, 32'h5A);
		rd_chk(SU_OFS_RXD, 32'h0, "rx data read-only");
		rd_chk(4'h2, 32'h0, "unmapped offset");
		$display("test regs done");
	endtask

	task automatic t_rx_errors;
		wr(SU_OFS_CTRL, 32'h5);
		send(8'hA5, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h21, "clean status");
		rd_chk(SU_OFS_RXD, 32'hA5, "clean data");
		chk(32'({rx_error_irq, rx_full_irq}), 32'h1, "clean irqs");
		send(8'h5A, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h23, "overrun status");
		rd_chk(SU_OFS_RXD, 32'hA5, "overrun data lost");
		chk(32'({rx_error_irq, rx_full_irq}), 32'h3, "overrun irqs");
		send(8'h11, 1'b0);
		rd_chk(SU_OFS_RXD, 32'hA5, "blocked while flagged");
		wr(SU_OFS_STAT, 32'h20);
		@(posedge hclk);
		chk(32'(rx_error_irq), 32'h0, "error irq cleared");
		wr(SU_OFS_CTRL, 32'h45);
		fmt <= su_fmt_type'(5'b01100);
		send(8'h3C, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h28, "parity status");
		rd_chk(SU_OFS_RXD, 32'h3C, "parity data kept");
		chk(32'({rx_error_irq, rx_full_irq}), 32'h2, "parity irqs");
		wr(SU_OFS_STAT, 32'h20);
		fmt <= su_fmt_type'(5'b01000);
		send(8'h77, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h21, "reception resumed");
		chk(32'(tc_rx_data), 32'h77, "controller data");
		tc_read();
		rd_chk(SU_OFS_STAT, 32'h20, "controller read clears full");
		wr(SU_OFS_CTRL, 32'h25);
		fmt <= su_fmt_type'(5'b00000);
		send(8'h00, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h24, "framing status");
		rd_chk(SU_OFS_RXD, 32'h0, "framing data kept");
		wr(SU_OFS_STAT, 32'h20);
		$display("test receive errors done");
	endtask

	// Parity enable is set but must not matter: both received characters fail even parity
	task automatic t_marker;
		wr(SU_OFS_CTRL, 32'h14D);
		fmt <= su_fmt_type'(5'b00010);
		send(8'h42, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h20, "data frame skipped");
		send(8'h03, 1'b1);
		rd_chk(SU_OFS_STAT, 32'h31, "ID frame status");
		rd_chk(SU_OFS_CTRL, 32'h145, "wait ended");
		rd_chk(SU_OFS_RXD, 32'h03, "ID data");
		chk(32'(rx_full_irq), 32'h1, "ID full irq");
		tc_read();
		send(8'h98, 1'b0);
		rd_chk(SU_OFS_STAT, 32'h21, "data frame marker");
		rd_chk(SU_OFS_RXD, 32'h98, "data frame data");
		$display("test marker done");
	endtask

	task automatic t_transmit;
		logic [31:0] x;
		int          n;
		wr(SU_OFS_STAT, 32'h60);
		wr(SU_OFS_CTRL, 32'h112);
		tc_tx_write <= 1'b1;
		tc_tx_data <= own_id;
		@(posedge hclk);
		tc_tx_write <= 1'b0;
		x = 32'h0;
		repeat (320) begin
			@(posedge hclk);
			x = x | 32'(!su_line_if_inst.dev_to_stn);
		end
		chk(x, 32'h0, "idle frame first");
		x = 32'h0;
		for (n = 0; x[SU_S_TXE] !== 1'b1; n++) begin
			if (n > 100)
				stuck("transmit empty");
			ahb(1'b0, SU_OFS_STAT, 32'h0, x);
		end
		chk(32'(tx_empty_irq), 32'h1, "tx empty irq");
		wr(SU_OFS_TXD, 32'h98);
		wr(SU_OFS_STAT, 32'h00);
		for (n = 0; rx_valid !== 1'b1; n++) begin
			if (n > 2000)
				stuck("station data");
			@(posedge hclk);
		end
		chk(32'(rx_data), 32'h98, "station got data after ID");
		chk(32'({rx_marker, rx_error}), 32'h0, "data marker sent");
		$display("test transmit done");
	endtask

	// Break is the last act; the line is left low to the end of the run
	task automatic t_break;
		repeat (40) @(posedge hclk);
		port_dir <= 1'b1;
		port_output_value <= 1'b0;
		wr(SU_OFS_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'(su_line_if_inst.dev_to_stn), 32'h0, "break on line");
		$display("test break done");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		port_dir = 1'b0;
		port_output_value = 1'b1;
		tc_rx_read = 1'b0;
		tc_tx_write = 1'b0;
		tc_tx_data = 8'h00;
		send_req = 1'b0;
		send_data = 8'h00;
		send_marker = 1'b0;
		own_id = 8'h03;
		fmt = su_fmt_type'(5'b00000);
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_rx_errors();
		t_marker();
		t_transmit();
		t_break();
		wrap_up();
	end
endmodule // su_device_bench

// ### testbench/su_line_chk.sv
// Line-level checks on both serial directions between the unit and its station
`timescale 1ns/1ps
module su_line_chk
	import su_pkg::*;
#(
	parameter int BASIC_DIV = SU_BASIC_DIV
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic dev_to_stn,
	input wire logic stn_to_dev
);
	localparam int BIT = SU_OVERSAMPLE * BASIC_DIV;
	logic [15:0] lo_d;
	logic [15:0] hi_d;
	logic [15:0] lo_s;
	logic [15:0] hi_s;

	// Run lengths saturate so a long idle never wraps into a short run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_d <= 16'h0;
			hi_d <= 16'(BIT);
		end else begin
			lo_d <= (dev_to_stn || lo_d == 16'hFFFF) ? (dev_to_stn ? 16'h0 : lo_d) : lo_d + 16'h1;
			hi_d <= (!dev_to_stn || hi_d == 16'hFFFF) ? (dev_to_stn ? hi_d : 16'h0) : hi_d + 16'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_s <= 16'h0;
			hi_s <= 16'(BIT);
		end else begin
			lo_s <= (stn_to_dev || lo_s == 16'hFFFF) ? (stn_to_dev ? 16'h0 : lo_s) : lo_s + 16'h1;
			hi_s <= (!stn_to_dev || hi_s == 16'hFFFF) ? (stn_to_dev ? hi_s : 16'h0) : hi_s + 16'h1;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_IDLE_HIGH: assert property ($rose(hresetn) |-> dev_to_stn && stn_to_dev)
		else $error("line not idle high after reset");
	AST_DEV_WHOLE_BITS: assert property ($rose(dev_to_stn) |-> (lo_d % BIT) == 0)
		else $error("device low run not whole bits");
	AST_DEV_MAX_LOW: assert property ($rose(dev_to_stn) |-> lo_d <= 16'(10 * BIT))
		else $error("device low run longer than a frame allows");
	AST_DEV_STOP_GAP: assert property ($fell(dev_to_stn) |-> hi_d >= 16'(BIT))
		else $error("device high run shorter than a bit");
	AST_DEV_START_HOLD: assert property ($fell(dev_to_stn) |=> !dev_to_stn [*4])
		else $error("device start bit too short");
	AST_STN_WHOLE_BITS: assert property ($rose(stn_to_dev) |-> (lo_s % BIT) == 0)
		else $error("station low run not whole bits");
	AST_STN_MAX_LOW: assert property ($rose(stn_to_dev) |-> lo_s <= 16'(10 * BIT))
		else $error("station low run longer than a frame allows");
	AST_STN_STOP_GAP: assert property ($fell(stn_to_dev) |-> hi_s >= 16'(BIT))
		else $error("station high run shorter than a bit");
	AST_STN_START_HOLD: assert property ($fell(stn_to_dev) |=> !stn_to_dev [*4])
		else $error("station start bit too short");

	COV_DEV_FRAME: cover property ($fell(dev_to_stn));
	COV_STN_FRAME: cover property ($rose(stn_to_dev));
	COV_STN_NINE: cover property ($rose(stn_to_dev) && lo_s == 16'(9 * BIT));
endmodule // su_line_chk
